// [rtl/scrb_top.v]
// system configuration register bank: boot report, line routing, break locks, memory error flags, trigger routing
//
// Functional notes
// - boot mode reads latched boot pin in bit0, option boot bit in bit1.
// - lines 0-3 pick port A, B, D or F pin by two-bit code.
// - lines 6,7 pick port A, B or C; code 11 is reserved.
// - lines 4,5,8-12 pick port A (0) or port B (1).
// - lines 13-15 pick port A, B or C; code 11 is reserved.
// - memory error lock bit1 is set-only; connects memory error to timer breaks.
// - processor hang lock bit0 is set-only; connects hang signal to timer breaks.
// - single error flag sets on correction event; software write of one clears it.
// - double error flag sets on uncorrectable event; software write of one clears it.
// - error location field holds the address of the latest memory error event.
// - corrected bit index reports the corrected data bit, zero means none.
// - single error enable gates the single error flag to the interrupt controller.
// - double error enable gates the double error flag onto the nmi.
// - bits 2 and 1 enable fast and slow crystal stuck interrupts; reset 0x7.
// - nmi rises only for an event whose enable bit is set.
// - latency field gives minimum cycles before vector fetch; zero means fastest.
// - trigger selector codes pick off, three internal triggers, edge flag, filtered inputs.
// - restart-start selector edge reinitialises, starts and updates the counter.
// - external clock selector edge advances the counter.
// - event selector edge enables the counter.
// - pause selector runs counter clock while trigger is high; code 100 reserved.
// - restart selector edge reinitialises the counter and updates shadow registers.
`include "scrb_defs.vh"

module scrb_top (
	// clock and reset
	input wire i_clock,
	input wire i_rst,
	// apb slave
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] i_pwdata,
	output wire [31:0] o_prdata,
	output wire o_pready,
	output wire o_pslverr,
	// boot straps
	input wire i_boot_select_pin,
	input wire i_boot_option_bit,
	// gpio pins feeding the interrupt lines
	input wire [15:0] i_port_a_pins,
	input wire [15:0] i_port_b_pins,
	input wire [15:0] i_port_c_pins,
	input wire [15:0] i_port_d_pins,
	input wire [15:0] i_port_f_pins,
	output wire [15:0] o_irq_lines,
	// memory error events and system signals
	input wire i_single_error_event,
	input wire i_double_error_event,
	input wire [11:0] i_error_location,
	input wire [5:0] i_corrected_bit_index,
	input wire i_cpu_hang,
	input wire i_fast_crystal_stuck,
	input wire i_slow_crystal_stuck,
	output wire [2:0] o_timer_break,
	output wire o_single_error_irq,
	output wire o_nmi,
	output wire [7:0] o_irq_latency,
	// timer trigger sources, 7 per timer: internal_trigger_a, internal_trigger_c, internal_trigger_d, edge flag, ch0 filt, ch1 filt, ext filt
	input wire [13:0] i_timer_trig_src,
	output wire [1:0] o_timer_reinit,
	output wire [1:0] o_timer_start,
	output wire [1:0] o_timer_ext_tick,
	output wire [1:0] o_timer_run_gate
);

	reg [31:0] lsel0_r;
	reg [31:0] lsel1_r;
	reg [31:0] lsel2_r;
	reg [31:0] lsel3_r;
	reg [1:0] lock_r;
	reg [1:0] flags_r;
	reg [3:0] info_en_r;
	reg [11:0] err_loc_r;
	reg [5:0] err_bit_r;
	reg [31:0] lat_r;
	reg [31:0] tmr_r [0:1];
	reg [31:0] prdata_r;
	reg [1:0] boot_mode_r;
	reg [2:0] boot_cnt_r;
	reg boot_pin_m_r;
	reg boot_pin_s_r;
	reg [79:0] pins_m_r;
	reg [79:0] pins_s_r;
	reg [1:0] stuck_m_r;
	reg [1:0] stuck_s_r;
	reg [2:0] break_r;
	reg single_irq_r;
	reg nmi_r;
	reg [15:0] irq_lines_r;
	reg [15:0] irq_lines_nxt;
	reg [31:0] rdata_nxt;
	reg map_hit;
	reg [1:0] flags_nxt;

	wire setup = i_psel & ~i_penable;
	wire wr = i_psel & i_penable & i_pwrite;
	wire [11:0] addr = {i_paddr[11:2], 2'b00};
	wire ecc_event = i_single_error_event | i_double_error_event;
	wire [15:0] pa = pins_s_r[15:0];
	wire [15:0] pb = pins_s_r[31:16];
	wire [15:0] pc = pins_s_r[47:32];
	wire [15:0] pd = pins_s_r[63:48];
	wire [15:0] pf = pins_s_r[79:64];

	// zero wait states: every access ends in its first access cycle
	assign o_pready = 1'b1;
	// unmapped words answer with an error and read as zero
	assign o_pslverr = i_psel & i_penable & ~map_hit;
	assign o_prdata = prdata_r;
	assign o_irq_lines = irq_lines_r;
	assign o_timer_break = break_r;
	assign o_single_error_irq = single_irq_r;
	assign o_nmi = nmi_r;
	assign o_irq_latency = lat_r[7:0];

	// two-flop synchronisers for pins and clock monitor levels
	always @(posedge i_clock) begin
		if (i_rst) begin
			pins_m_r <= 80'h0;
			pins_s_r <= 80'h0;
			stuck_m_r <= 2'h0;
			stuck_s_r <= 2'h0;
			boot_pin_m_r <= 1'b0;
			boot_pin_s_r <= 1'b0;
		end else begin
			pins_m_r <= {i_port_f_pins, i_port_d_pins, i_port_c_pins, i_port_b_pins, i_port_a_pins};
			pins_s_r <= pins_m_r;
			stuck_m_r <= {i_fast_crystal_stuck, i_slow_crystal_stuck};
			stuck_s_r <= stuck_m_r;
			boot_pin_m_r <= i_boot_select_pin;
			boot_pin_s_r <= boot_pin_m_r;
		end
	end

	// boot straps are caught once, a few edges after reset release
	always @(posedge i_clock) begin
		if (i_rst) begin
			boot_cnt_r <= 3'h0;
			boot_mode_r <= 2'h0;
		end else if (boot_cnt_r != `SCRB_BOOT_LATCH_EDGE) begin
			boot_cnt_r <= boot_cnt_r + 3'h1;
			if (boot_cnt_r == `SCRB_BOOT_LATCH_EDGE - 3'h1) begin
				boot_mode_r <= {i_boot_option_bit, boot_pin_s_r};
			end
		end
	end

	// interrupt line source routing
	always @* begin
		irq_lines_nxt = 16'h0;
		case (lsel0_r[1:0])
			2'h0: irq_lines_nxt[0] = pa[0];
			2'h1: irq_lines_nxt[0] = pb[0];
			2'h2: irq_lines_nxt[0] = pd[0];
			default: irq_lines_nxt[0] = pf[0];
		endcase
		case (lsel0_r[5:4])
			2'h0: irq_lines_nxt[1] = pa[1];
			2'h1: irq_lines_nxt[1] = pb[1];
			2'h2: irq_lines_nxt[1] = pd[1];
			default: irq_lines_nxt[1] = pf[1];
		endcase
		case (lsel0_r[9:8])
			2'h0: irq_lines_nxt[2] = pa[2];
			2'h1: irq_lines_nxt[2] = pb[2];
			2'h2: irq_lines_nxt[2] = pd[2];
			default: irq_lines_nxt[2] = pf[2];
		endcase
		case (lsel0_r[13:12])
			2'h0: irq_lines_nxt[3] = pa[3];
			2'h1: irq_lines_nxt[3] = pb[3];
			2'h2: irq_lines_nxt[3] = pd[3];
			default: irq_lines_nxt[3] = pf[3];
		endcase
		irq_lines_nxt[4] = lsel1_r[0] ? pb[4] : pa[4];
		irq_lines_nxt[5] = lsel1_r[4] ? pb[5] : pa[5];
		// reserved code 11 leaves the line low
		case (lsel1_r[9:8])
			2'h0: irq_lines_nxt[6] = pa[6];
			2'h1: irq_lines_nxt[6] = pb[6];
			2'h2: irq_lines_nxt[6] = pc[6];
			default: irq_lines_nxt[6] = 1'b0;
		endcase
		case (lsel1_r[13:12])
			2'h0: irq_lines_nxt[7] = pa[7];
			2'h1: irq_lines_nxt[7] = pb[7];
			2'h2: irq_lines_nxt[7] = pc[7];
			default: irq_lines_nxt[7] = 1'b0;
		endcase
		irq_lines_nxt[8] = lsel2_r[0] ? pb[8] : pa[8];
		irq_lines_nxt[9] = lsel2_r[4] ? pb[9] : pa[9];
		irq_lines_nxt[10] = lsel2_r[8] ? pb[10] : pa[10];
		irq_lines_nxt[11] = lsel2_r[12] ? pb[11] : pa[11];
		irq_lines_nxt[12] = lsel3_r[0] ? pb[12] : pa[12];
		case (lsel3_r[5:4])
			2'h0: irq_lines_nxt[13] = pa[13];
			2'h1: irq_lines_nxt[13] = pb[13];
			2'h2: irq_lines_nxt[13] = pc[13];
			default: irq_lines_nxt[13] = 1'b0;
		endcase
		case (lsel3_r[9:8])
			2'h0: irq_lines_nxt[14] = pa[14];
			2'h1: irq_lines_nxt[14] = pb[14];
			2'h2: irq_lines_nxt[14] = pc[14];
			default: irq_lines_nxt[14] = 1'b0;
		endcase
		case (lsel3_r[13:12])
			2'h0: irq_lines_nxt[15] = pa[15];
			2'h1: irq_lines_nxt[15] = pb[15];
			2'h2: irq_lines_nxt[15] = pc[15];
			default: irq_lines_nxt[15] = 1'b0;
		endcase
	end

	// read mux and address decode
	always @* begin
		rdata_nxt = 32'h0;
		map_hit = 1'b1;
		case (addr)
			`SCRB_OFF_BOOT: rdata_nxt = {30'h0, boot_mode_r};
			`SCRB_OFF_LSEL0: rdata_nxt = lsel0_r;
			`SCRB_OFF_LSEL1: rdata_nxt = lsel1_r;
			`SCRB_OFF_LSEL2: rdata_nxt = lsel2_r;
			`SCRB_OFF_LSEL3: rdata_nxt = lsel3_r;
			`SCRB_OFF_LOCK: rdata_nxt = {30'h0, lock_r};
			`SCRB_OFF_FLAGS: rdata_nxt = {30'h0, flags_r};
			// reserved bit0 of the info register keeps its reset value of one
			`SCRB_OFF_INFO: rdata_nxt = {err_loc_r, 4'h0, err_bit_r, 5'h0, info_en_r, 1'b1};
			`SCRB_OFF_LAT: rdata_nxt = lat_r;
			`SCRB_OFF_TMRA: rdata_nxt = tmr_r[0];
			`SCRB_OFF_TMRC: rdata_nxt = tmr_r[1];
			default: map_hit = 1'b0;
		endcase
	end

	// error flags: a new event wins over a clear in the same cycle
	always @* begin
		flags_nxt = flags_r;
		// both flags are write-one-to-clear
		if (wr && addr == `SCRB_OFF_FLAGS) begin
			flags_nxt = flags_r & ~i_pwdata[1:0];
		end
		if (i_single_error_event) begin
			flags_nxt[`SCRB_BIT_SINGLE_FLAG] = 1'b1;
		end
		if (i_double_error_event) begin
			flags_nxt[`SCRB_BIT_DOUBLE_FLAG] = 1'b1;
		end
	end

	// register writes, taken in the access phase
	always @(posedge i_clock) begin
		if (i_rst) begin
			lsel0_r <= `SCRB_RST_ZERO;
			lsel1_r <= `SCRB_RST_ZERO;
			lsel2_r <= `SCRB_RST_ZERO;
			lsel3_r <= `SCRB_RST_ZERO;
			lock_r <= 2'h0;
			flags_r <= 2'h0;
			info_en_r <= `SCRB_RST_INFO_EN;
			err_loc_r <= 12'h0;
			err_bit_r <= 6'h0;
			lat_r <= `SCRB_RST_ZERO;
			tmr_r[0] <= `SCRB_RST_ZERO;
			tmr_r[1] <= `SCRB_RST_ZERO;
			prdata_r <= 32'h0;
		end else begin
			flags_r <= flags_nxt;
			// read data is caught in the setup cycle and stands through the access phase
			if (setup && !i_pwrite) begin
				prdata_r <= rdata_nxt;
			end
			if (ecc_event) begin
				err_loc_r <= i_error_location;
			end
			if (i_single_error_event) begin
				err_bit_r <= i_corrected_bit_index;
			end
			// reserved bits are dropped on write and read back as zero, save info bit0 which reads one
			if (wr) begin
				case (addr)
					`SCRB_OFF_LSEL0: lsel0_r <= i_pwdata & `SCRB_MASK_LSEL0;
					`SCRB_OFF_LSEL1: lsel1_r <= i_pwdata & `SCRB_MASK_LSEL1;
					`SCRB_OFF_LSEL2: lsel2_r <= i_pwdata & `SCRB_MASK_LSEL2;
					`SCRB_OFF_LSEL3: lsel3_r <= i_pwdata & `SCRB_MASK_LSEL3;
					// lock bits only ever set; reset alone clears them
					`SCRB_OFF_LOCK: lock_r <= lock_r | i_pwdata[1:0];
					`SCRB_OFF_INFO: info_en_r <= i_pwdata[`SCRB_INFO_EN_MSB:`SCRB_INFO_EN_LSB];
					`SCRB_OFF_LAT: lat_r <= i_pwdata & `SCRB_MASK_LAT;
					`SCRB_OFF_TMRA: tmr_r[0] <= i_pwdata & `SCRB_MASK_TMR;
					`SCRB_OFF_TMRC: tmr_r[1] <= i_pwdata & `SCRB_MASK_TMR;
					default: ;
				endcase
			end
		end
	end

	// break, interrupt and nmi outputs
	always @(posedge i_clock) begin
		if (i_rst) begin
			break_r <= 3'h0;
			single_irq_r <= 1'b0;
			nmi_r <= 1'b0;
			irq_lines_r <= 16'h0;
		end else begin
			irq_lines_r <= irq_lines_nxt;
			// a memory error gives a one-cycle break per event, a hang holds the break
			break_r <= {3{(lock_r[`SCRB_BIT_ECC_LOCK] & ecc_event) |
				(lock_r[`SCRB_BIT_HANG_LOCK] & i_cpu_hang)}};
			single_irq_r <= flags_r[`SCRB_BIT_SINGLE_FLAG] & info_en_r[3];
			// nmi is the or of every enabled non-maskable source
			nmi_r <= (flags_r[`SCRB_BIT_DOUBLE_FLAG] & info_en_r[2]) |
				(stuck_s_r[1] & info_en_r[1]) | (stuck_s_r[0] & info_en_r[0]);
		end
	end

	// trigger routing to timer slave modes, one copy per timer
	genvar t;
	generate
		for (t = 0; t < 2; t = t + 1) begin : g_tmr
			reg [6:0] src_d_r;
			reg reinit_r;
			reg start_r;
			reg tick_r;
			reg gate_r;
			wire [6:0] src = i_timer_trig_src[7*t+6:7*t];
			// edge history resets low, the idle level of every trigger source
			wire [6:0] rise = src & ~src_d_r;
			wire [31:0] cfg = tmr_r[t];
			wire [2:0] s_rs = cfg[`SCRB_SEL_RESTART_START+2:`SCRB_SEL_RESTART_START];
			wire [2:0] s_ck = cfg[`SCRB_SEL_EXT_CLOCK+2:`SCRB_SEL_EXT_CLOCK];
			wire [2:0] s_ev = cfg[`SCRB_SEL_GATE_EDGE+2:`SCRB_SEL_GATE_EDGE];
			wire [2:0] s_pa = cfg[`SCRB_SEL_PAUSE+2:`SCRB_SEL_PAUSE];
			wire [2:0] s_re = cfg[`SCRB_SEL_RESTART+2:`SCRB_SEL_RESTART];
			// code 0 is off, codes 1..7 index the source vector
			wire e_rs = (s_rs != `SCRB_SEL_OFF) & rise[s_rs - 3'h1];
			wire e_ck = (s_ck != `SCRB_SEL_OFF) & rise[s_ck - 3'h1];
			wire e_ev = (s_ev != `SCRB_SEL_OFF) & rise[s_ev - 3'h1];
			wire e_re = (s_re != `SCRB_SEL_OFF) & rise[s_re - 3'h1];
			// reserved pause code behaves as pause disabled
			wire pa_on = (s_pa != `SCRB_SEL_OFF) & (s_pa != `SCRB_SEL_PAUSE_RSVD);
			always @(posedge i_clock) begin
				if (i_rst) begin
					src_d_r <= 7'h0;
					reinit_r <= 1'b0;
					start_r <= 1'b0;
					tick_r <= 1'b0;
					gate_r <= 1'b1;
				end else begin
					src_d_r <= src;
					reinit_r <= e_rs | e_re;
					start_r <= e_rs | e_ev;
					tick_r <= e_ck;
					gate_r <= ~pa_on | src[s_pa - 3'h1];
				end
			end
			assign o_timer_reinit[t] = reinit_r;
			assign o_timer_start[t] = start_r;
			assign o_timer_ext_tick[t] = tick_r;
			assign o_timer_run_gate[t] = gate_r;
		end
	endgenerate

endmodule // scrb_top

// [rtl/scrb_defs.vh]
// register map, field layout, reset values and timing counts of the system configuration bank
`ifndef SCRB_DEFS_VH
`define SCRB_DEFS_VH
`define SCRB_OFF_BOOT 12'h000
`define SCRB_OFF_LSEL0 12'h008
`define SCRB_OFF_LSEL1 12'h00c
`define SCRB_OFF_LSEL2 12'h010
`define SCRB_OFF_LSEL3 12'h014
`define SCRB_OFF_LOCK 12'h018
`define SCRB_OFF_FLAGS 12'h01c
`define SCRB_OFF_INFO 12'h028
`define SCRB_OFF_LAT 12'h100
`define SCRB_OFF_TMRA 12'h110
`define SCRB_OFF_TMRC 12'h118
`define SCRB_MASK_LSEL0 32'h00003333
`define SCRB_MASK_LSEL1 32'h00003331
`define SCRB_MASK_LSEL2 32'h00001111
`define SCRB_MASK_LSEL3 32'h00003331
`define SCRB_MASK_LAT 32'h000000ff
`define SCRB_MASK_TMR 32'h77777777
`define SCRB_RST_ZERO 32'h00000000
`define SCRB_RST_INFO_EN 4'h3
`define SCRB_BIT_HANG_LOCK 0
`define SCRB_BIT_ECC_LOCK 1
`define SCRB_BIT_DOUBLE_FLAG 0
`define SCRB_BIT_SINGLE_FLAG 1
`define SCRB_INFO_EN_LSB 1
`define SCRB_INFO_EN_MSB 4
`define SCRB_SEL_RESTART_START 28
`define SCRB_SEL_EXT_CLOCK 24
`define SCRB_SEL_GATE_EDGE 20
`define SCRB_SEL_PAUSE 16
`define SCRB_SEL_RESTART 12
`define SCRB_SEL_OFF 3'h0
`define SCRB_SEL_PAUSE_RSVD 3'h4
`define SCRB_BOOT_LATCH_EDGE 3'h4
`endif

// [sim/scrb_checker.sv]
// concurrent checks on the configuration bank ports
module scrb_checker (
	// clock and reset
	input wire i_clock,
	input wire i_rst,
	// bus and event inputs
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [11:0] i_paddr,
	input wire i_single_error_event,
	input wire i_double_error_event,
	input wire i_cpu_hang,
	input wire [13:0] i_timer_trig_src,
	// observed outputs
	input wire [2:0] o_timer_break,
	input wire o_single_error_irq,
	input wire [7:0] o_irq_latency,
	input wire [1:0] o_timer_reinit,
	input wire [1:0] o_timer_start,
	input wire [1:0] o_timer_ext_tick,
	input wire [1:0] o_timer_run_gate
);
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_rst);
	wire apb_wr = i_psel && i_penable && i_pwrite;
	break_cause_a: assert property (o_timer_break != 3'h0 |-> $past(i_cpu_hang) ||
		$past(i_single_error_event) || $past(i_double_error_event)) else $error("break without cause");
	break_equal_a: assert property (o_timer_break == 3'h0 || o_timer_break == 3'h7)
		else $error("break bits differ");
	tick_cause_a: assert property (o_timer_ext_tick[1] |-> $past(|i_timer_trig_src[13:7]))
		else $error("tick without trigger");
	start_cause_a: assert property (o_timer_start[0] |-> $past(|i_timer_trig_src[6:0]))
		else $error("start without trigger");
	reinit_pulse_a: assert property (o_timer_reinit[0] |=> !o_timer_reinit[0])
		else $error("reinit longer than one cycle");
	gate_run_a: assert property ($past(i_timer_trig_src[6:0]) == 7'h7f &&
		$past(i_timer_trig_src[6:0], 2) == 7'h7f |-> o_timer_run_gate[0]) else $error("gate low");
	latency_write_a: assert property ($changed(o_irq_latency) |->
		$past(apb_wr && i_paddr[11:2] == 10'h040)) else $error("latency changed unasked");
	single_irq_a: assert property ($rose(o_single_error_irq) |->
		$past(i_single_error_event, 2) || $past(apb_wr, 2)) else $error("single irq without cause");
endmodule // scrb_checker

bind scrb_top scrb_checker scrb_checker_i (.*);

// [sim/test_scrb_top.sv]
// register and event tests of the configuration bank
`include "scrb_defs.vh"
module test_scrb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_clock = 1'b0, i_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
	logic [11:0] i_paddr = 12'h0, i_error_location = 12'h0;
	logic [31:0] i_pwdata = 32'h0, o_prdata;
	logic i_boot_select_pin = 1'b1, i_boot_option_bit = 1'b1, i_cpu_hang = 1'b0;
	logic [15:0] i_port_a_pins = 16'h0, i_port_b_pins = 16'h0, i_port_c_pins = 16'h0;
	logic [15:0] i_port_d_pins = 16'h0, i_port_f_pins = 16'h0, o_irq_lines;
	logic i_single_error_event = 1'b0, i_double_error_event = 1'b0, i_fast_crystal_stuck = 1'b0;
	logic i_slow_crystal_stuck = 1'b0, o_pready, o_pslverr, o_single_error_irq, o_nmi;
	logic [5:0] i_corrected_bit_index = 6'h0;
	logic [13:0] i_timer_trig_src = 14'h0;
	logic [2:0] o_timer_break;
	logic [7:0] o_irq_latency;
	logic [1:0] o_timer_reinit, o_timer_start, o_timer_ext_tick, o_timer_run_gate;
	int err_total = 0, checks = 0, cycles = 0;
	logic perr;
	logic [11:0] ra [7] = '{`SCRB_OFF_LSEL0, `SCRB_OFF_LSEL1, `SCRB_OFF_LSEL2, `SCRB_OFF_LSEL3,
		`SCRB_OFF_LAT, `SCRB_OFF_TMRA, `SCRB_OFF_TMRC};
	logic [31:0] rm [7] = '{`SCRB_MASK_LSEL0, `SCRB_MASK_LSEL1, `SCRB_MASK_LSEL2, `SCRB_MASK_LSEL3,
		`SCRB_MASK_LAT, `SCRB_MASK_TMR, `SCRB_MASK_TMR};
	scrb_top scrb_top_i (.*);
	initial begin
		forever #5 i_clock = ~i_clock;
	end
	task close_out;
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge i_clock) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			err_total++;
			close_out();
		end
	end
	task ck(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge i_clock);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clock);
		i_penable <= 1'b1;
		do @(posedge i_clock); while (o_pready !== 1'b1);
		q = o_prdata;
		perr = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0, q);
		ck(q, e);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask
	// one memory error event, break pulse seen one edge later
	task ev(input logic dbl, input logic [11:0] loc, input logic [5:0] bi);
		@(posedge i_clock);
		i_double_error_event <= dbl;
		i_single_error_event <= !dbl;
		i_error_location <= loc;
		i_corrected_bit_index <= bi;
		@(posedge i_clock);
		i_double_error_event <= 1'b0;
		i_single_error_event <= 1'b0;
		@(negedge i_clock);
		ck(o_timer_break, 3'h7);
		@(posedge i_clock);
	endtask
	// rising edge on one trigger source, {reinit, start, tick} sampled next cycle
	task pulse(input int b, input logic [5:0] e);
		@(posedge i_clock);
		i_timer_trig_src <= 14'h1 << b;
		@(posedge i_clock);
		@(negedge i_clock);
		ck({o_timer_reinit, o_timer_start, o_timer_ext_tick}, e);
		@(posedge i_clock);
		i_timer_trig_src <= 14'h0;
	endtask
	initial begin
		repeat (16) @(posedge i_clock);
		i_rst <= 1'b0;
		repeat (6) @(posedge i_clock);
		rd(`SCRB_OFF_BOOT, 32'h3);
		ck({o_pready, perr}, 2'h2);
		rd(`SCRB_OFF_INFO, 32'h7);
		for (int k = 0; k < 7; k++) begin
			rd(ra[k], 32'h0);
			wr(ra[k], rm[k]);
			rd(ra[k], rm[k]);
			wr(ra[k], 32'h0);
		end
		wr(`SCRB_OFF_LAT, 32'h5a);
		@(posedge i_clock);
		ck(o_irq_latency, 8'h5a);
		wr(`SCRB_OFF_LOCK, 32'h1);
		wr(`SCRB_OFF_LOCK, 32'h0);
		rd(`SCRB_OFF_LOCK, 32'h1);
		wr(`SCRB_OFF_LOCK, 32'h2);
		rd(`SCRB_OFF_LOCK, 32'h3);
		wr(`SCRB_OFF_INFO, 32'h0000001f);
		rd(`SCRB_OFF_INFO, 32'h1f);
		rd(12'h004, 32'h0);
		ck(perr, 1'b1);
		wr(`SCRB_OFF_LSEL0, 32'h3210);
		wr(`SCRB_OFF_LSEL1, 32'h2310);
		wr(`SCRB_OFF_LSEL2, 32'h1010);
		wr(`SCRB_OFF_LSEL3, 32'h2101);
		i_port_a_pins <= 16'h2551;
		i_port_b_pins <= 16'h5a62;
		i_port_c_pins <= 16'h80c0;
		i_port_d_pins <= 16'h0044;
		i_port_f_pins <= 16'h0048;
		repeat (5) @(posedge i_clock);
		ck(o_irq_lines, 16'hffbf);
		i_port_a_pins <= ~16'h2551;
		i_port_b_pins <= ~16'h5a62;
		i_port_c_pins <= ~16'h80c0;
		i_port_d_pins <= ~16'h0044;
		i_port_f_pins <= ~16'h0048;
		repeat (5) @(posedge i_clock);
		ck(o_irq_lines, 16'h0);
		ev(1'b1, 12'habc, 6'h0);
		rd(`SCRB_OFF_FLAGS, 32'h1);
		rd(`SCRB_OFF_INFO, 32'habc0001f);
		ck(o_nmi, 1'b1);
		ev(1'b0, 12'h123, 6'h05);
		rd(`SCRB_OFF_FLAGS, 32'h3);
		rd(`SCRB_OFF_INFO, 32'h1230141f);
		ck(o_single_error_irq, 1'b1);
		wr(`SCRB_OFF_FLAGS, 32'h1);
		rd(`SCRB_OFF_FLAGS, 32'h2);
		ck(o_nmi, 1'b0);
		wr(`SCRB_OFF_FLAGS, 32'h2);
		rd(`SCRB_OFF_FLAGS, 32'h0);
		ck(o_single_error_irq, 1'b0);
		wr(`SCRB_OFF_INFO, 32'h1);
		ev(1'b1, 12'h001, 6'h0);
		i_fast_crystal_stuck <= 1'b1;
		repeat (6) @(posedge i_clock);
		ck(o_nmi, 1'b0);
		wr(`SCRB_OFF_INFO, 32'h5);
		repeat (3) @(posedge i_clock);
		ck(o_nmi, 1'b1);
		i_fast_crystal_stuck <= 1'b0;
		i_slow_crystal_stuck <= 1'b1;
		wr(`SCRB_OFF_INFO, 32'h3);
		repeat (3) @(posedge i_clock);
		ck(o_nmi, 1'b1);
		wr(`SCRB_OFF_INFO, 32'h5);
		repeat (3) @(posedge i_clock);
		ck(o_nmi, 1'b0);
		i_slow_crystal_stuck <= 1'b0;
		i_cpu_hang <= 1'b1;
		repeat (3) @(posedge i_clock);
		ck(o_timer_break, 3'h7);
		i_cpu_hang <= 1'b0;
		wr(`SCRB_OFF_TMRA, 32'h10000000);
		pulse(0, 6'b010100);
		wr(`SCRB_OFF_TMRA, 32'h00400000);
		pulse(3, 6'b000100);
		wr(`SCRB_OFF_TMRA, 32'h00007000);
		pulse(6, 6'b010000);
		for (int c = 1; c < 8; c++) begin
			wr(`SCRB_OFF_TMRC, c << 24);
			pulse(6 + c, 6'b000010);
		end
		wr(`SCRB_OFF_TMRA, 32'h00050000);
		repeat (3) @(posedge i_clock);
		ck(o_timer_run_gate, 2'b10);
		i_timer_trig_src <= 14'h007f;
		repeat (3) @(posedge i_clock);
		ck(o_timer_run_gate, 2'b11);
		i_timer_trig_src <= 14'h0;
		wr(`SCRB_OFF_TMRA, 32'h00040000);
		repeat (3) @(posedge i_clock);
		ck(o_timer_run_gate, 2'b11);
		i_rst <= 1'b1;
		i_boot_select_pin <= 1'b0;
		repeat (16) @(posedge i_clock);
		i_rst <= 1'b0;
		rd(`SCRB_OFF_LOCK, 32'h0);
		rd(`SCRB_OFF_FLAGS, 32'h0);
		rd(`SCRB_OFF_BOOT, 32'h2);
		ck(o_irq_latency, 8'h0);
		i_cpu_hang <= 1'b1;
		repeat (3) @(posedge i_clock);
		ck(o_timer_break, 3'h0);
		i_cpu_hang <= 1'b0;
		close_out();
	end
endmodule // test_scrb_top
